// ==== rtl/pdt_pkg.sv ====
// Purpose: Shared constants for the programmable delay timer/counter.
// Assumes: 100 MHz system clock; time base built from a cycle counter.
// Notes:   Times are kept in ns, and cycle counts are derived from them.

package pdt_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 10;
  // Stand-in for the analogue RC period; a plain default
  localparam int unsigned TB_PERIOD_NS     = 10000;
  localparam int unsigned TB_PULSE_MIN_NS  = 500;

  localparam int unsigned TB_PERIOD_CYC    = TB_PERIOD_NS / CLK_PERIOD_NS;
  // Pulse must be strictly longer than the minimum, so one cycle is added
  localparam int unsigned TB_LOW_CYC       = (TB_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;

  localparam int unsigned TB_PHASE_W       = 16;
  localparam logic [TB_PHASE_W-1:0] TB_PHASE_LAST =
    TB_PHASE_W'(TB_PERIOD_CYC - 1);
  localparam logic [TB_PHASE_W-1:0] TB_LOW_START  =
    TB_PHASE_W'(TB_PERIOD_CYC - TB_LOW_CYC);

  // ----------------------------------------------------------------
  // Counter and pin synchroniser
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W            = 8;
  localparam logic [CNT_W-1:0] CNT_RESET   = 8'h00;
  localparam logic [CNT_W-1:0] TAPS_IDLE   = 8'hff;
  localparam int unsigned SYNC_W           = 14;

  // Bit positions within the synchronised pin vector
  localparam int unsigned PIN_START        = 0;
  localparam int unsigned PIN_STOP         = 1;
  localparam int unsigned PIN_TB           = 2;
  localparam int unsigned PIN_SYNC         = 3;
  localparam int unsigned PIN_TB_OFF       = 4;
  localparam int unsigned PIN_FEEDBACK     = 5;
  localparam int unsigned PIN_SEL_LSB      = 6;

endpackage : pdt_pkg

// ==== rtl/pdt_pin_sync.sv ====
// Purpose: Three-stage synchroniser for asynchronous pins.
// Assumes: Inputs are slow against the 100 MHz clock.
// Notes:   A change is taken only once stages two and three agree.

`timescale 1ns/1ps
`default_nettype none

module pdt_pin_sync
  import pdt_pkg::*;
#(
  parameter int unsigned WIDTH = SYNC_W
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Pins and clean levels
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit, keep the old level while stages two and three disagree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_o <= '0;
    end else begin
      level_o <= (s2_q & s3_q) | (level_o & (s2_q ^ s3_q));
    end
  end

endmodule : pdt_pin_sync

`default_nettype wire

// ==== rtl/pdt_timebase.sv ====
// Purpose: Digital stand-in for the time-base oscillator.
// Assumes: Period and pulse width fixed by package constants.
// Notes:   A low pulse ends each period; sync realigns the phase.

`timescale 1ns/1ps
`default_nettype none

module pdt_timebase
  import pdt_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Control
  input  wire logic run_i,
  input  wire logic sync_rise_i,
  // Open-collector drive of the time-base pin
  output logic      pulse_oe_o
);

  logic [TB_PHASE_W-1:0] phase_q;
  logic [TB_PHASE_W-1:0] phase_d;

  // ----------------------------------------------------------------
  // Phase
  // ----------------------------------------------------------------
  always_comb begin
    phase_d = phase_q;
    if (!run_i) begin
      phase_d = '0;
    end else if (sync_rise_i && !pulse_oe_o) begin
      // Lock to sync; a pulse in flight is never cut short
      phase_d = '0;
    end else if (phase_q == TB_PHASE_LAST) begin
      phase_d = '0;
    end else begin
      phase_d = phase_q + TB_PHASE_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Low pulse of TB_LOW_CYC at each period end; released when stopped
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pulse_oe_o <= 1'b0;
    end else begin
      pulse_oe_o <= run_i && (phase_d >= TB_LOW_START);
    end
  end

endmodule : pdt_timebase

`default_nettype wire

// ==== rtl/pdt_timer.sv ====
// What this block does
// - Power-up: every tap output released high
// - Start pulse runs time base, taps low
// - Each time-base pulse adds one count
// - Reset state: time base stopped, taps high
// - Stop pulse ends cycle, back to reset
// - Start pulses ignored while cycle runs
// - Simultaneous start and stop: start wins
// - Tap feedback self-resets at programmed count
// - No feedback: counts until external stop
// - Counter steps on time-base falling edges
// - Time-base pin high idle, pulses running
// - Time-base low pulse exceeds 500 ns
// - Time-base pin held low freezes count
// - Joined taps read low if any low
// - Bus low N periods then high
// - N is sum of joined tap weights
// - Cascaded units reach 256 to 65536 periods
// - Time base locks to sync divided m
// - Highest tap is word's most significant bit
//
// Purpose: Control flip-flop and 8-bit counter of a programmable timer.
// Assumes: All pins asynchronous; open-collector pins as level/enable pairs.
// Notes:   Counting latency from a pin edge is five clock cycles.

`timescale 1ns/1ps
`default_nettype none

module pdt_timer
  import pdt_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Cycle control pins
  input  wire logic             cycle_start_input_i,
  input  wire logic             cycle_stop_i,
  // Time-base pulse pin, open collector
  input  wire logic             timebase_pulse_pin_i,
  output logic                  timebase_pulse_pin_o,
  output logic                  timebase_pulse_pin_oe_o,
  // Time-base shaping pins
  input  wire logic             sync_modulation_input_i,
  input  wire logic             timing_network_pin_low_i,
  // Output bus wiring
  input  wire logic             feedback_switch_i,
  input  wire logic [CNT_W-1:0] tap_select_i,
  // Count taps, open collector
  output logic      [CNT_W-1:0] count_tap_o,
  output logic      [CNT_W-1:0] count_tap_oe_o,
  // Observed levels
  output logic                  output_bus_o,
  output logic      [CNT_W-1:0] count_word_o,
  output logic                  cycle_active_o
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_lvl;

  assign pin_raw = {tap_select_i,
                    feedback_switch_i,
                    timing_network_pin_low_i,
                    sync_modulation_input_i,
                    timebase_pulse_pin_i,
                    cycle_stop_i,
                    cycle_start_input_i};

  // External clock on the pin is slow enough for this
  pdt_pin_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .pin_i   (pin_raw),
    .level_o (pin_lvl)
  );

  logic             start_lvl;
  logic             stop_lvl;
  logic             tb_lvl;
  logic             sync_lvl;
  logic             tb_off_lvl;
  logic             feedback_lvl;
  logic [CNT_W-1:0] sel_lvl;

  assign start_lvl    = pin_lvl[PIN_START];
  assign stop_lvl     = pin_lvl[PIN_STOP];
  assign tb_lvl       = pin_lvl[PIN_TB];
  assign sync_lvl     = pin_lvl[PIN_SYNC];
  assign tb_off_lvl   = pin_lvl[PIN_TB_OFF];
  assign feedback_lvl = pin_lvl[PIN_FEEDBACK];
  assign sel_lvl      = pin_lvl[PIN_SEL_LSB +: CNT_W];

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  logic start_prev_q;
  logic stop_prev_q;
  logic tb_prev_q;
  logic sync_prev_q;

  // Pins start low-idle, the pulled-up time-base pin included
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_prev_q <= 1'b0;
      stop_prev_q  <= 1'b0;
      tb_prev_q    <= 1'b0;
      sync_prev_q  <= 1'b0;
    end else begin
      start_prev_q <= start_lvl;
      stop_prev_q  <= stop_lvl;
      tb_prev_q    <= tb_lvl;
      sync_prev_q  <= sync_lvl;
    end
  end

  logic start_rise;
  logic stop_rise;
  logic tb_fall;
  logic sync_rise;

  assign start_rise = start_lvl & ~start_prev_q;
  assign stop_rise  = stop_lvl & ~stop_prev_q;
  assign tb_fall    = ~tb_lvl & tb_prev_q;
  assign sync_rise  = sync_lvl & ~sync_prev_q;

  // ----------------------------------------------------------------
  // Wired-OR bus helper
  // ----------------------------------------------------------------
  // Bus is high only when every joined tap is high
  function automatic logic bus_level(input logic [CNT_W-1:0] taps,
                                     input logic [CNT_W-1:0] sel);
    bus_level = &(taps | ~sel);
  endfunction

  // ----------------------------------------------------------------
  // Control flip-flop and counter
  // ----------------------------------------------------------------
  logic             running_q;
  logic             running_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             fb_hit;
  logic             stop_evt;
  logic             start_evt;

  // First time all joined taps go high is count N
  assign fb_hit   = running_q & feedback_lvl & (|sel_lvl) & bus_level(count_q, sel_lvl);
  assign stop_evt = stop_rise | fb_hit;

  // Ignored while running unless a stop lands in the same cycle
  assign start_evt = start_rise & (~running_q | stop_evt);

  always_comb begin
    running_d = running_q;
    count_d   = count_q;
    if (start_evt) begin
      running_d = 1'b1;
      count_d   = CNT_RESET;
    end else if (stop_evt) begin
      running_d = 1'b0;
      count_d   = CNT_RESET;
    end else if (running_q && tb_fall) begin
      // Clamped pin gives no falling edge, so count holds
      // Wraps freely when no tap is fed back
      count_d   = count_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      running_q <= 1'b0;
    end else begin
      running_q <= running_d;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_q <= CNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  logic tb_run;

  // Stopped in reset, or when the timing network is pulled low
  assign tb_run = running_q & ~tb_off_lvl;

  pdt_timebase u_tb (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .run_i       (tb_run),
    .sync_rise_i (sync_rise),
    .pulse_oe_o  (timebase_pulse_pin_oe_o)
  );

  // ----------------------------------------------------------------
  // Pin drive and observed outputs
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] tap_level;

  // Released taps read high; in a cycle they follow the count
  assign tap_level = running_d ? count_d : TAPS_IDLE;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_tap_o          <= '0;
      timebase_pulse_pin_o <= 1'b0;
    end else begin
      count_tap_o          <= '0;
      timebase_pulse_pin_o <= 1'b0;
    end
  end

  // A tap conducts while its count bit is zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_tap_oe_o <= '0;
    end else begin
      count_tap_oe_o <= ~tap_level;
    end
  end

  // Bus goes low at start and high after N periods
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      output_bus_o <= 1'b1;
    end else begin
      output_bus_o <= bus_level(tap_level, sel_lvl);
    end
  end

  // Tap 7 lands in the top bit of the word
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_word_o   <= TAPS_IDLE;
      cycle_active_o <= 1'b0;
    end else begin
      count_word_o   <= tap_level;
      cycle_active_o <= running_d;
    end
  end

endmodule : pdt_timer

`default_nettype wire

// ==== verif/pdt_ext_logic.sv ====
// Purpose: Far-side logic on the time-base wire: pull-up, clamp, clock.
// Assumes: Wire level is low if any party pulls it low.
// Notes:   Clock phases are 105 cycles each.
`timescale 1ns/1ps
`default_nettype none
module pdt_ext_logic (
  input  wire logic clk_i,
  input  wire logic run_i,
  input  wire logic clamp_i,
  input  wire logic tb_oe_i,
  output logic      tb_wire_o
);
  logic [7:0] ph_q;
  // A low phase always runs to its end, so no clock pulse is cut short
  always_ff @(posedge clk_i) begin
    if (ph_q >= 8'h69) begin
      ph_q <= (ph_q == 8'hd1) ? 8'h00 : ph_q + 8'h01;
    end else begin
      ph_q <= run_i ? ph_q + 8'h01 : 8'h00;
    end
  end
  // Stopped clock rests high on the pull-up
  assign tb_wire_o = ~tb_oe_i & ~clamp_i & ~(ph_q >= 8'h69);
endmodule // pdt_ext_logic
`default_nettype wire

// ==== verif/pdt_timer_chk.sv ====
// Purpose: Port assertions for the timer.
// Assumes: Open-collector levels read through pull-ups.
// Notes:   Windows allow for the pin synchroniser.
`timescale 1ns/1ps
`default_nettype none
module pdt_timer_chk
  import pdt_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             nrst_i,
  input wire logic             timebase_pulse_pin_i,
  input wire logic             feedback_switch_i,
  input wire logic [CNT_W-1:0] tap_select_i,
  input wire logic             timebase_pulse_pin_oe_o,
  input wire logic [CNT_W-1:0] count_tap_oe_o,
  input wire logic             output_bus_o,
  input wire logic [CNT_W-1:0] count_word_o,
  input wire logic             cycle_active_o,
  input wire logic [CNT_W-1:0] count_tap_o,
  input wire logic             timebase_pulse_pin_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] low_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) low_q <= 8'h00;
    else low_q <= timebase_pulse_pin_oe_o ? low_q + 8'h01 : 8'h00;
  end
  sequence s_tb_fall;
    $fell(timebase_pulse_pin_i) && cycle_active_o;
  endsequence
  sequence s_at_count;
    feedback_switch_i && tap_select_i != 8'h00 && cycle_active_o && (count_word_o & tap_select_i) == tap_select_i;
  endsequence
  chk_idle_taps: assert property (!cycle_active_o |->
    count_tap_oe_o == 8'h00 && count_word_o == TAPS_IDLE)
    else $error("taps not released while idle");
  chk_idle_tb: assert property (!cycle_active_o && $past(!cycle_active_o) |->
    !timebase_pulse_pin_oe_o)
    else $error("time base driven while idle");
  chk_start_clear: assert property ($rose(cycle_active_o) |->
    count_word_o == CNT_RESET && count_tap_oe_o == TAPS_IDLE)
    else $error("start did not clear count");
  chk_pulse_width: assert property ($fell(timebase_pulse_pin_oe_o) && cycle_active_o |->
    low_q == 8'(TB_LOW_CYC))
    else $error("time-base pulse width wrong");
  chk_word_taps: assert property (count_word_o == ~count_tap_oe_o)
    else $error("word differs from tap levels");
  chk_bus_or: assert property (output_bus_o == &(count_word_o | ~tap_select_i))
    else $error("output bus not wired-OR of taps");
  chk_sink_only: assert property (count_tap_o == 8'h00 && !timebase_pulse_pin_o)
    else $error("open-collector pin driven high");
  chk_count_step: assert property (cycle_active_o && $past(cycle_active_o)
    && $changed(count_word_o) |-> count_word_o == $past(count_word_o) + 8'h01 || count_word_o == 8'h00)
    else $error("count moved by other than one");
  chk_fall_counts: assert property (s_tb_fall |-> ##[3:7] ($changed(count_word_o) || !cycle_active_o))
    else $error("falling edge not counted");
  chk_clamp_hold: assert property (!timebase_pulse_pin_i [*8] |->
    $stable(count_word_o) || $changed(cycle_active_o))
    else $error("count moved while pin low");
  chk_fb_stop: assert property (s_at_count |-> ##[1:2] !cycle_active_o)
    else $error("no self-reset at programmed count");
endmodule // pdt_timer_chk
bind pdt_timer pdt_timer_chk i_chk (.clk_i(clk_i), .nrst_i(nrst_i), .timebase_pulse_pin_i(timebase_pulse_pin_i),
  .feedback_switch_i(feedback_switch_i), .tap_select_i(tap_select_i), .timebase_pulse_pin_oe_o(timebase_pulse_pin_oe_o),
  .count_tap_oe_o(count_tap_oe_o), .output_bus_o(output_bus_o), .count_word_o(count_word_o),
  .cycle_active_o(cycle_active_o), .count_tap_o(count_tap_o), .timebase_pulse_pin_o(timebase_pulse_pin_o));
`default_nettype wire

// ==== verif/pdt_timer_test.sv ====
// Purpose: Self-checking bench for the timer.
// Assumes: Far side modelled by pdt_ext_logic.
// Notes:   Self-reset runs use the external clock to stay short.
`timescale 1ns/1ps
`default_nettype none
module pdt_timer_test
  import pdt_pkg::*;
;
  logic       clk_i = 1'b0;
  logic       nrst_i = 1'b0;
  logic       start_i = 1'b0;
  logic       stop_i = 1'b0;
  logic       sync_i = 1'b0;
  logic       tnp_i = 1'b0;
  logic       fb_i = 1'b0;
  logic       run_i = 1'b0;
  logic       clamp_i = 1'b0;
  logic [7:0] sel_i = 8'h00;
  logic       tb_wire, tb_oe, bus, act;
  logic [7:0] tap_oe, word;
  logic [7:0] sels [4];
  int         n_mismatch = 0;
  int         samples_checked = 0;
  int         n, k;
  always #5 clk_i = ~clk_i;
  pdt_timer i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .cycle_start_input_i(start_i), .cycle_stop_i(stop_i),
    .timebase_pulse_pin_i(tb_wire), .timebase_pulse_pin_o(), .timebase_pulse_pin_oe_o(tb_oe),
    .sync_modulation_input_i(sync_i), .timing_network_pin_low_i(tnp_i), .feedback_switch_i(fb_i),
    .tap_select_i(sel_i), .count_tap_o(), .count_tap_oe_o(tap_oe), .output_bus_o(bus),
    .count_word_o(word), .cycle_active_o(act));
  pdt_ext_logic i_ext (.clk_i(clk_i), .run_i(run_i), .clamp_i(clamp_i), .tb_oe_i(tb_oe), .tb_wire_o(tb_wire));
  function automatic logic [7:0] exp_bus(logic [7:0] cnt, logic [7:0] sel);
    return {7'h00, &(cnt | ~sel)};
  endfunction
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int c);
    repeat (c) @(posedge clk_i);
  endtask
  // Pin pulse held 4 cycles so the synchroniser sees it
  task automatic pulse(logic a, logic b);
    start_i <= a;
    stop_i <= b;
    cyc(4);
    start_i <= 1'b0;
    stop_i <= 1'b0;
    cyc(8);
  endtask
  // Falls of the wire seen while the cycle runs
  task automatic count_falls(output int f);
    logic w;
    f = 0;
    w = tb_wire;
    for (int i = 0; i < 60000 && act === 1'b1; i++) begin
      @(negedge clk_i);
      if (w && !tb_wire && act) f++;
      w = tb_wire;
    end
    @(posedge clk_i);
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(90000);
    n_mismatch++;
    $display("ERROR watchdog expected done seen timeout");
    end_of_test();
  end
  initial begin
    void'($urandom(32'h8dc96589));
    sels[0] = 8'h01;
    sels[1] = 8'h31;
    sels[2] = 8'($urandom_range(40, 2));
    sels[3] = 8'($urandom_range(40, 2));
    cyc(5);
    nrst_i <= 1'b1;
    cyc(3);
    chk("idle word", TAPS_IDLE, word);
    chk("idle bus", 8'h01, {7'h00, bus});
    sel_i <= 8'($urandom_range(255, 1));
    cyc(10);
    pulse(1'b1, 1'b0);
    chk("start word", CNT_RESET, word);
    cyc(300);
    sync_i <= 1'b1;
    cyc(4);
    sync_i <= 1'b0;
    for (k = 0; k < 2000 && tb_oe !== 1'b1; k++) cyc(1);
    chk("sync phase", 8'h01, {7'h00, k >= 940 && k <= 960});
    // Sync landing inside a pulse must leave the phase alone
    sync_i <= 1'b1;
    cyc(4);
    sync_i <= 1'b0;
    cyc(16);
    chk("count one", 8'h01, word);
    pulse(1'b1, 1'b0);
    chk("retrigger", 8'h01, word);
    cyc(30);
    for (k = 0; k < 2000 && tb_oe !== 1'b1; k++) cyc(1);
    chk("sync in pulse", 8'h01, {7'h00, k >= 930 && k <= 945});
    cyc(1032);
    chk("free run", 8'h03, word);
    chk("run bus", exp_bus(8'h03, sel_i), {7'h00, bus});
    cyc(100);
    clamp_i <= 1'b1;
    cyc(2500);
    chk("clamped", 8'h04, word);
    clamp_i <= 1'b0;
    cyc(10);
    pulse(1'b1, 1'b1);
    chk("both word", CNT_RESET, word);
    chk("both act", 8'h01, {7'h00, act});
    pulse(1'b0, 1'b1);
    chk("stop word", TAPS_IDLE, word);
    chk("stop taps", 8'h00, tap_oe);
    tnp_i <= 1'b1;
    fb_i <= 1'b1;
    foreach (sels[i]) begin
      sel_i <= sels[i];
      cyc(10);
      pulse(1'b1, 1'b0);
      chk("bus low", 8'h00, {7'h00, bus});
      run_i <= 1'b1;
      count_falls(n);
      run_i <= 1'b0;
      chk("periods", sels[i], 8'(n));
      chk("bus back", 8'h01, {7'h00, bus});
    end
    end_of_test();
  end
endmodule // pdt_timer_test
`default_nettype wire
